// *** rtl/iog_map.vh ***
// constants for the i/o cell gearing path
`ifndef IOG_MAP_VH
`define IOG_MAP_VH
`define IOG_GEAR_X1 2'h0
`define IOG_GEAR_X2 2'h1
`define IOG_GEAR_71 2'h2
`define IOG_BITS_X1 3'h2
`define IOG_BITS_X2 3'h4
`define IOG_BITS_71 3'h7
`define IOG_WORD_W 7
`define IOG_GROUP_LANES 16
`define IOG_SFIFO_AW 2
`define IOG_BUF_AW 5
`define IOG_BUF_DEPTH 6'h20
`define IOG_DLY_W 3
`define IOG_DLY_TAPS 8
`define IOG_TRI_RESET 1'h1
`endif

// *** rtl/iog_fifo.v ***
// synchronous valid/ready fifo, flip-flop storage
`timescale 1ns/1ns
module iog_fifo #(
  parameter W = 8,
  parameter AW = 5,
  parameter [AW:0] DEPTH = 6'h20
) (
  input wire i_clk,
  input wire i_reset,
  input wire [W-1:0] i_in_data,
  input wire i_in_valid,
  output wire o_in_ready,
  output wire [W-1:0] o_out_data,
  output wire o_out_valid,
  input wire i_out_ready
);
  // depth must be a power of two so the pointers wrap by themselves
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0] cnt_r;
  wire push;
  wire pop;

  assign o_in_ready = (cnt_r != DEPTH);
  assign o_out_valid = (cnt_r != {(AW+1){1'b0}});
  assign o_out_data = mem[rp_r];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always @(posedge i_clk) begin
    if (push) begin
      mem[wp_r] <= i_in_data;
    end
  end

  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_r <= wp_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rp_r <= rp_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        cnt_r <= cnt_r - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule

// *** rtl/iog_io_pad_cell.v ***
// i/o cell register path: input gearing, output gearing, tristate
// Summary of operation
// - three register blocks: input, output and tristate, each with its own selection
// - side cells gear input words at single or double rate
// - seven-to-one receive produces a seven-bit word from a shared path
// - first input stage captures pad data on both fast edge clock edges
// - second stage realigns bits into words under core alignment request
// - third stage hands the aligned word to the core on the system clock
// - top cells offer only single-rate input gearing
// - every pin has its own strobe fifo ahead of the gearing
// - strobe fifo written on delayed strobe, read on fast edge clock
// - one fifo control per strobe group drives all lanes' pointers
// - output block registers core data before the pad
// - side cells serialise output at 1x, 2x or 7:1
// - top cells serialise output at 1x only
// - tristate takes one sdr control or a two-bit double-rate control
// - strobe out from strobe clock, data from the 270-degree clock
// - reset clears output block; tristate block resets with tristate control high and pad enable low
// - programmable delay ahead of input registers on all edges
// - programmable delay between output registers and pad
// - sixteen cells form one strobe group sharing fifo control
`timescale 1ns/1ns
`include "iog_map.vh"
module iog_io_pad_cell #(
  parameter LANES = `IOG_GROUP_LANES,
  parameter EDGE_TOP = 0
) (
  input wire i_clk,
  input wire i_reset,
  input wire [LANES-1:0] i_pad_data,
  input wire i_fast_edge_clock,
  input wire i_strobe_in,
  input wire i_strobe_out_clock,
  input wire i_data_out_shifted_clock,
  input wire [1:0] i_in_gear,
  input wire i_mem_mode,
  input wire [`IOG_DLY_W-1:0] i_in_delay,
  input wire i_word_align_request,
  output wire [LANES*`IOG_WORD_W-1:0] o_in_word,
  output wire o_in_valid,
  input wire i_in_ready,
  output wire o_in_overflow,
  input wire [1:0] i_out_gear,
  input wire [`IOG_WORD_W-1:0] i_out_word,
  input wire i_out_valid,
  output wire o_out_ready,
  input wire [`IOG_DLY_W-1:0] i_out_delay,
  input wire i_tristate_ctl_in,
  input wire [1:0] i_tristate_ctl_pair,
  input wire i_tri_double,
  output wire o_pad_out,
  output wire o_pad_oe,
  output wire o_tristate_ctl_out,
  output wire o_strobe_out,
  output wire o_strobe_oe
);
  localparam WW = `IOG_WORD_W;
  localparam SW = LANES + 4;
  localparam FEC = LANES;
  localparam STR = LANES + 1;
  localparam SOC = LANES + 2;
  localparam DOS = LANES + 3;
  localparam SAW = `IOG_SFIFO_AW;
  localparam TAPS = `IOG_DLY_TAPS;

  function [2:0] gear_bits;
    input [1:0] g;
    begin
      if (g == `IOG_GEAR_X2) begin
        gear_bits = `IOG_BITS_X2;
      end else if (g == `IOG_GEAR_71) begin
        gear_bits = `IOG_BITS_71;
      end else begin
        gear_bits = `IOG_BITS_X1;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; the second and third stages are read by logic
  reg [SW-1:0] s1_r;
  reg [SW-1:0] s2_r;
  reg [SW-1:0] s3_r;
  reg [1:0] arm_r;
  wire sync_ok;
  wire fec_edge;
  wire str_edge;
  wire dos_edge;

  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      s1_r <= {SW{1'b0}};
      s2_r <= {SW{1'b0}};
      s3_r <= {SW{1'b0}};
      arm_r <= 2'h0;
    end else begin
      if (arm_r != 2'h3) begin
        arm_r <= arm_r + 2'h1;
      end
      s1_r <= {i_data_out_shifted_clock, i_strobe_out_clock, i_strobe_in,
               i_fast_edge_clock, i_pad_data};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a clock pin left high across reset would look like an edge; wait for the pipe to fill
  assign sync_ok = (arm_r == 2'h3);
  assign fec_edge = (s2_r[FEC] ^ s3_r[FEC]) & sync_ok;
  assign str_edge = (s2_r[STR] ^ s3_r[STR]) & sync_ok;
  assign dos_edge = (s2_r[DOS] ^ s3_r[DOS]) & sync_ok;

  ////////////////////////////////////////////////////////////////////////////
  // input block: shared strobe fifo control and word framing
  reg [SAW:0] sf_wp_r;
  reg [SAW:0] sf_rp_r;
  reg [2:0] bc_r;
  reg slip_r;
  reg w2v_r;
  reg ovf_r;
  wire sf_empty;
  wire sf_full;
  wire sf_wr;
  wire bit_ev;
  wire [1:0] in_gear_eff;
  wire [2:0] in_nb;
  wire [2:0] in_last;
  wire [7:0] in_mask;
  wire word_done;
  wire buf_in_ready;
  wire [LANES*WW-1:0] w2_all;

  // top cells have single-rate gearing only
  assign in_gear_eff = (EDGE_TOP != 0) ? `IOG_GEAR_X1 : i_in_gear;
  assign in_nb = gear_bits(in_gear_eff);
  assign in_mask = (8'h01 << in_nb) - 8'h01;
  assign in_last = slip_r ? in_nb : in_nb - 3'h1;
  // pointers are shared by every lane of the group
  assign sf_empty = (sf_wp_r == sf_rp_r);
  assign sf_full = (sf_wp_r[SAW] != sf_rp_r[SAW]) &&
                   (sf_wp_r[SAW-1:0] == sf_rp_r[SAW-1:0]);
  // equal strobe and edge clock rates keep this from filling
  assign sf_wr = i_mem_mode && str_edge && !sf_full;
  assign bit_ev = fec_edge && (!i_mem_mode || !sf_empty);
  assign word_done = bit_ev && (bc_r == in_last);

  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      sf_wp_r <= {(SAW+1){1'b0}};
      sf_rp_r <= {(SAW+1){1'b0}};
      bc_r <= 3'h0;
      slip_r <= 1'b0;
      w2v_r <= 1'b0;
      ovf_r <= 1'b0;
    end else begin
      if (sf_wr) begin
        sf_wp_r <= sf_wp_r + {{SAW{1'b0}}, 1'b1};
      end
      if (bit_ev && i_mem_mode) begin
        sf_rp_r <= sf_rp_r + {{SAW{1'b0}}, 1'b1};
      end
      if (word_done) begin
        bc_r <= 3'h0;
      end else if (bit_ev) begin
        bc_r <= bc_r + 3'h1;
      end
      // a new request in the cycle the slip is used keeps it pending
      if (i_word_align_request) begin
        slip_r <= 1'b1;
      end else if (word_done) begin
        slip_r <= 1'b0;
      end
      if (word_done) begin
        w2v_r <= 1'b1;
      end else if (buf_in_ready) begin
        w2v_r <= 1'b0;
      end
      // a held word that the full buffer could not take is overwritten
      if (word_done && w2v_r && !buf_in_ready) begin
        ovf_r <= 1'b1;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < LANES; gi = gi + 1) begin : g_lane
      reg [TAPS-1:0] dl_r;
      reg [(1<<SAW)-1:0] sfm_r;
      reg [WW-1:0] sh_r;
      reg [WW-1:0] w2_r;
      wire pad_d;
      wire in_bit;

      assign pad_d = dl_r[i_in_delay];
      assign in_bit = i_mem_mode ? sfm_r[sf_rp_r[SAW-1:0]] : pad_d;
      assign w2_all[gi*WW +: WW] = w2_r;

      always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
          dl_r <= {TAPS{1'b0}};
          sfm_r <= {(1<<SAW){1'b0}};
          sh_r <= {WW{1'b0}};
          w2_r <= {WW{1'b0}};
        end else begin
          dl_r <= {dl_r[TAPS-2:0], s2_r[gi]};
          if (sf_wr) begin
            sfm_r[sf_wp_r[SAW-1:0]] <= pad_d;
          end
          if (bit_ev) begin
            sh_r <= {sh_r[WW-2:0], in_bit};
          end
          if (word_done) begin
            w2_r <= {sh_r[WW-2:0], in_bit} & in_mask[WW-1:0];
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // third stage: buffer then core-facing register
  wire [LANES*WW-1:0] buf_data;
  wire buf_valid;
  reg [LANES*WW-1:0] qw_r;
  reg qv_r;
  wire buf_take;

  assign buf_take = !qv_r || i_in_ready;

  iog_fifo #(
    .W(LANES*WW),
    .AW(`IOG_BUF_AW),
    .DEPTH(`IOG_BUF_DEPTH)
  ) u_buf (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_in_data(w2_all),
    .i_in_valid(w2v_r),
    .o_in_ready(buf_in_ready),
    .o_out_data(buf_data),
    .o_out_valid(buf_valid),
    .i_out_ready(buf_take)
  );

  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      qw_r <= {(LANES*WW){1'b0}};
      qv_r <= 1'b0;
    end else if (buf_take) begin
      qw_r <= buf_data;
      qv_r <= buf_valid;
    end
  end

  assign o_in_word = qw_r;
  assign o_in_valid = qv_r;
  assign o_in_overflow = ovf_r;

  ////////////////////////////////////////////////////////////////////////////
  // output block: serialiser on the shifted data clock
  reg [WW-1:0] osh_r;
  reg [2:0] ocnt_r;
  reg obusy_r;
  reg ordy_r;
  reg obit_r;
  reg [TAPS-1:0] odl_r;
  reg pad_r;
  reg stb_r;
  reg stb_oe_r;
  wire [1:0] out_gear_eff;
  wire [2:0] out_nb;
  wire out_take;

  assign out_gear_eff = (EDGE_TOP != 0) ? `IOG_GEAR_X1 : i_out_gear;
  assign out_nb = gear_bits(out_gear_eff);
  assign out_take = i_out_valid && ordy_r;

  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      osh_r <= {WW{1'b0}};
      ocnt_r <= 3'h0;
      obusy_r <= 1'b0;
      ordy_r <= 1'b0;
      obit_r <= 1'b0;
      odl_r <= {TAPS{1'b0}};
      pad_r <= 1'b0;
      stb_r <= 1'b0;
      stb_oe_r <= 1'b0;
    end else begin
      if (out_take) begin
        // left-justify so the first bit always leaves from the top
        osh_r <= i_out_word << (3'h7 - out_nb);
        ocnt_r <= out_nb;
        obusy_r <= 1'b1;
        ordy_r <= 1'b0;
      end else if (obusy_r && dos_edge) begin
        obit_r <= osh_r[WW-1];
        osh_r <= {osh_r[WW-2:0], 1'b0};
        ocnt_r <= ocnt_r - 3'h1;
        if (ocnt_r == 3'h1) begin
          obusy_r <= 1'b0;
          ordy_r <= 1'b1;
        end
      end else if (!obusy_r) begin
        ordy_r <= 1'b1;
      end
      odl_r <= {odl_r[TAPS-2:0], obit_r};
      pad_r <= odl_r[i_out_delay];
      stb_r <= obusy_r & s2_r[SOC];
      stb_oe_r <= obusy_r;
    end
  end

  assign o_out_ready = ordy_r;
  assign o_pad_out = pad_r;
  assign o_strobe_out = stb_r;
  assign o_strobe_oe = stb_oe_r;

  ////////////////////////////////////////////////////////////////////////////
  // tristate block
  reg tq_r;
  reg oe_r;
  reg tsel_r;
  reg tq_nxt;

  always @* begin
    tq_nxt = tq_r;
    if (!i_tri_double) begin
      tq_nxt = i_tristate_ctl_in;
    end else if (dos_edge) begin
      tq_nxt = i_tristate_ctl_pair[tsel_r];
    end
  end

  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      tq_r <= `IOG_TRI_RESET;
      oe_r <= 1'b0;
      tsel_r <= 1'b0;
    end else begin
      tq_r <= tq_nxt;
      oe_r <= ~tq_nxt;
      if (!i_tri_double) begin
        tsel_r <= 1'b0;
      end else if (dos_edge) begin
        tsel_r <= ~tsel_r;
      end
    end
  end

  assign o_tristate_ctl_out = tq_r;
  assign o_pad_oe = oe_r;
endmodule

// *** testbench/iog_pad_cell_props.sv ***
// assertions on the i/o cell ports
`timescale 1ns/1ns
`include "iog_map.vh"
module iog_pad_cell_props #(
  parameter LANES = 16
) (
  input wire i_clk,
  input wire i_reset,
  input wire i_tristate_ctl_in,
  input wire i_tri_double,
  input wire i_out_valid,
  input wire i_in_ready,
  input wire o_out_ready,
  input wire o_pad_oe,
  input wire o_tristate_ctl_out,
  input wire o_strobe_out,
  input wire o_strobe_oe,
  input wire o_in_valid,
  input wire [LANES*`IOG_WORD_W-1:0] o_in_word,
  input wire o_in_overflow
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  sequence s_take;
    i_out_valid && o_out_ready;
  endsequence
  sequence s_busy;
    !o_out_ready [*2];
  endsequence
  a_tri_sdr_follow: assert property (!i_tri_double && $past(!i_tri_double) |->
    o_tristate_ctl_out == $past(i_tristate_ctl_in)) else $error("tristate lag wrong");
  a_oe_inverse: assert property (o_pad_oe == !o_tristate_ctl_out)
    else $error("pad enable not inverse");
  a_ready_drop: assert property (s_take |=> s_busy)
    else $error("ready stayed high");
  a_ready_back: assert property (s_take |-> ##[2:1000] o_out_ready)
    else $error("serialiser hung");
  a_strobe_idle: assert property (!o_strobe_oe |-> !o_strobe_out)
    else $error("strobe while idle");
  a_word_holds: assert property (o_in_valid && !i_in_ready |=> o_in_valid && $stable(o_in_word))
    else $error("word dropped");
  a_ovf_sticky: assert property (o_in_overflow |=> o_in_overflow)
    else $error("overflow cleared");
  a_ovf_full: assert property ($rose(o_in_overflow) |-> o_in_valid)
    else $error("overflow while empty");
endmodule
bind iog_io_pad_cell iog_pad_cell_props #(.LANES(LANES)) u_props (.i_clk(i_clk),
  .i_reset(i_reset), .i_tristate_ctl_in(i_tristate_ctl_in), .i_tri_double(i_tri_double),
  .i_out_valid(i_out_valid), .i_in_ready(i_in_ready), .o_out_ready(o_out_ready),
  .o_pad_oe(o_pad_oe), .o_tristate_ctl_out(o_tristate_ctl_out), .o_strobe_out(o_strobe_out),
  .o_strobe_oe(o_strobe_oe), .o_in_valid(o_in_valid), .o_in_word(o_in_word),
  .o_in_overflow(o_in_overflow));

// *** testbench/iog_link_model.sv ***
// source-synchronous link partner driving the pads
`timescale 1ns/1ns
module iog_link_model (
  input wire i_mem_mode,
  output reg [15:0] o_pad_data,
  output reg o_fast_edge_clock,
  output reg o_strobe_in
);
  initial begin
    o_pad_data = 16'h0000;
    o_fast_edge_clock = 1'b0;
    o_strobe_in = 1'b0;
  end
  // msb first; clocks stand still between frames
  task send(input [6:0] bits, input integer n);
    integer k;
    begin
      for (k = n - 1; k >= 0; k = k - 1) begin
        o_pad_data = {16{bits[k]}};
        #20;
        if (i_mem_mode) o_strobe_in = ~o_strobe_in;
        #30;
        o_fast_edge_clock = ~o_fast_edge_clock;
        #12;
      end
      // released line shows the inverse, not a stale value
      o_pad_data = ~o_pad_data;
    end
  endtask
endmodule

// *** testbench/iog_io_pad_cell_tb_top.sv ***
// self-checking bench for the i/o cell path
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module iog_io_pad_cell_tb_top;
  reg clk = 0, rst = 1, dclk = 0, sclk = 0, mem = 0, algn = 0, ird = 0;
  reg [1:0] ig = 0, og = 0, tp = 0;
  reg [2:0] idl = 0, odl = 0;
  reg [6:0] ow = 0;
  reg ov = 0, tin = 1, tdbl = 0;
  wire [15:0] pad;
  wire fec, stb, ovf, iv, ordy, po, poe, tq, so, soe;
  wire [111:0] iw;
  integer fails = 0, comparisons = 0, cyc = 0;
  always #5 clk = ~clk;
  always #31 sclk = ~sclk;
  // offset keeps data clock toggles off the system clock's rising edge
  initial begin
    #1;
    forever begin
      #62 dclk = ~dclk;
      #63 dclk = ~dclk;
    end
  end
  iog_link_model link (.i_mem_mode(mem), .o_pad_data(pad), .o_fast_edge_clock(fec),
    .o_strobe_in(stb));
  iog_io_pad_cell dut (.i_clk(clk), .i_reset(rst), .i_pad_data(pad), .i_fast_edge_clock(fec),
    .i_strobe_in(stb), .i_strobe_out_clock(sclk), .i_data_out_shifted_clock(dclk),
    .i_in_gear(ig), .i_mem_mode(mem), .i_in_delay(idl), .i_word_align_request(algn),
    .o_in_word(iw), .o_in_valid(iv), .i_in_ready(ird), .o_in_overflow(ovf),
    .i_out_gear(og), .i_out_word(ow), .i_out_valid(ov), .o_out_ready(ordy),
    .i_out_delay(odl), .i_tristate_ctl_in(tin), .i_tristate_ctl_pair(tp),
    .i_tri_double(tdbl), .o_pad_out(po), .o_pad_oe(poe), .o_tristate_ctl_out(tq),
    .o_strobe_out(so), .o_strobe_oe(soe));
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      end_of_test;
    end
  end
  task cyc_n(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task do_reset;
    begin
      rst = 1;
      cyc_n(3);
      `CHK({tq, poe, ordy}, 3'h4)
      rst = 0;
      cyc_n(2);
    end
  endtask
  task wait_hi(input integer who, input reg lvl);
    integer m;
    begin
      m = 0;
      while (((who == 0 ? iv : ordy) !== lvl) && m < 300) begin
        cyc_n(1);
        m = m + 1;
      end
      `CHK(who == 0 ? iv : ordy, lvl)
    end
  endtask
  task t_rx(input [1:0] g, input [2:0] d, input [6:0] w, input integer nb);
    begin
      ig = g;
      idl = d;
      do_reset;
      link.send(w, nb);
      wait_hi(0, 1'b1);
      `CHK(iw[6:0], w)
      `CHK(iw[111:105], w)
      ird = 1;
      cyc_n(1);
      ird = 0;
      $display("rx gear %0d done", g);
    end
  endtask
  task t_align;
    begin
      ig = 0;
      do_reset;
      algn = 1;
      cyc_n(1);
      algn = 0;
      link.send(7'h03, 3);
      wait_hi(0, 1'b1);
      `CHK(iw[6:0], 7'h03)
      $display("align done");
    end
  endtask
  task t_ovf;
    begin
      do_reset;
      repeat (40) link.send(7'h02, 2);
      `CHK(ovf, 1'b1)
      `CHK(iw[6:0], 7'h02)
      ird = 1;
      wait_hi(0, 1'b0);
      ird = 0;
      `CHK(ovf, 1'b1)
      $display("overflow done");
    end
  endtask
  task t_tx(input [1:0] g, input [2:0] d, input [6:0] w, input integer nb);
    integer k;
    begin
      og = g;
      odl = d;
      ow = w;
      do_reset;
      @(dclk);
      cyc_n(3);
      ov = 1;
      cyc_n(1);
      ov = 0;
      for (k = nb - 1; k >= 0; k = k - 1) begin
        @(dclk);
        cyc_n(1);
        `CHK(soe, 1'b1)
        cyc_n(4 + d);
        `CHK(po, w[k])
      end
      wait_hi(1, 1'b1);
      $display("tx gear %0d done", g);
    end
  endtask
  task t_tri;
    reg a;
    begin
      do_reset;
      tin = 0;
      cyc_n(2);
      `CHK({tq, poe}, 2'h1)
      tp = 2'h2;
      tdbl = 1;
      @(dclk);
      cyc_n(5);
      a = tq;
      @(dclk);
      cyc_n(5);
      `CHK(a ^ tq, 1'b1)
      $display("tristate done");
    end
  endtask
  initial begin
    t_rx(2'h0, 3'h0, 7'h02, 2);
    t_rx(2'h1, 3'h1, 7'h0b, 4);
    t_rx(2'h2, 3'h2, 7'h5a, 7);
    mem = 1;
    t_rx(2'h0, 3'h0, 7'h01, 2);
    mem = 0;
    t_align;
    t_ovf;
    t_tx(2'h0, 3'h0, 7'h02, 2);
    t_tx(2'h1, 3'h0, 7'h0d, 4);
    t_tx(2'h2, 3'h1, 7'h4b, 7);
    t_tri;
    end_of_test;
  end
endmodule
